// ==== bench/udc_counter_asserts.sv ====
`default_nettype none

module udc_counter_asserts (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_up_count_clock,
  input wire logic i_down_count_clock,
  input wire logic i_master_clear,
  input wire logic i_preset_load_n,
  input wire logic i_preset_bit0,
  input wire logic i_preset_bit1,
  input wire logic i_preset_bit2,
  input wire logic i_preset_bit3,
  input wire logic o_count_bit0,
  input wire logic o_count_bit1,
  input wire logic o_count_bit2,
  input wire logic o_count_bit3,
  input wire logic o_carry_out_n,
  input wire logic o_borrow_out_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;
  logic [3:0] pre;

  assign cnt = {o_count_bit3, o_count_bit2, o_count_bit1, o_count_bit0};
  assign pre = {i_preset_bit3, i_preset_bit2, i_preset_bit1, i_preset_bit0};

  // Pins reach the outputs three edges after they change
  default clocking dc @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_reset_n);

  ////////////////////////////////////////////////////////////////////////////
  clear_zero_a: assert property (i_master_clear [*4] |-> cnt == 4'h0)
    else $error("count not zero under clear");
  clear_wins_a: assert property (i_master_clear && !i_preset_load_n |-> ##3 cnt == 4'h0)
    else $error("load beat clear");
  load_copy_a: assert property ((!i_preset_load_n && !i_master_clear && $stable(pre)) [*4]
    |-> cnt == pre) else $error("preset not copied");
  carry_level_a: assert property (o_carry_out_n ==
    !(cnt == 4'hf && !$past(i_up_count_clock, 3))) else $error("carry level wrong");
  borrow_level_a: assert property (o_borrow_out_n ==
    !(cnt == 4'h0 && !$past(i_down_count_clock, 3))) else $error("borrow level wrong");
  up_step_a: assert property ($rose(i_up_count_clock) && $past(i_down_count_clock)
    && i_down_count_clock && !i_master_clear && i_preset_load_n ##2
    (!i_master_clear && i_preset_load_n) |=> cnt == $past(cnt) + 4'h1) else $error("no up step");
  down_step_a: assert property ($rose(i_down_count_clock)
    && $past(i_up_count_clock) && i_up_count_clock && !i_master_clear && i_preset_load_n ##2
    (!i_master_clear && i_preset_load_n) |=> cnt == $past(cnt) - 4'h1) else $error("no down step");
  both_rise_a: assert property ($rose(i_up_count_clock) && $rose(i_down_count_clock)
    && !i_master_clear && i_preset_load_n |-> ##3 $stable(cnt)) else $error("double rise counted");
endmodule

bind udc_counter udc_counter_asserts i_udc_counter_asserts (
  .i_ref_clk, .i_reset_n, .i_up_count_clock, .i_down_count_clock, .i_master_clear,
  .i_preset_load_n, .i_preset_bit0, .i_preset_bit1, .i_preset_bit2, .i_preset_bit3,
  .o_count_bit0, .o_count_bit1, .o_count_bit2, .o_count_bit3, .o_carry_out_n, .o_borrow_out_n
);

`default_nettype wire

// ==== bench/udc_counter_tb.sv ====
`default_nettype none

module udc_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        reset_n;
  logic        up;
  logic        down;
  logic        clr;
  logic        load_n;
  logic [3:0]  pre;
  logic [3:0]  cnt;
  logic        carry_n;
  logic        borrow_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [31:0] rd;
  int          error_cnt;
  int          checked;

  always #5 ref_clk = ~ref_clk;

  udc_pin_driver i_udc_pin_driver (.i_ref_clk(ref_clk), .o_up_count_clock(up),
    .o_down_count_clock(down), .o_master_clear(clr), .o_preset_load_n(load_n), .o_preset(pre));

  udc_counter i_udc_counter (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
    .i_up_count_clock(up), .i_down_count_clock(down), .i_master_clear(clr),
    .i_preset_load_n(load_n), .i_preset_bit0(pre[0]), .i_preset_bit1(pre[1]),
    .i_preset_bit2(pre[2]), .i_preset_bit3(pre[3]), .o_count_bit0(cnt[0]),
    .o_count_bit1(cnt[1]), .o_count_bit2(cnt[2]), .o_count_bit3(cnt[3]),
    .o_carry_out_n(carry_n), .o_borrow_out_n(borrow_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pins(input logic u, d, c, l, input logic [3:0] p);
    i_udc_pin_driver.drive(u, d, c, l, p, 4);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= udc_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, udc_pkg::HRESP_OKAY});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_clear_load;
    pins(1'b1, 1'b1, 1'b1, 1'b0, 4'hd);
    chk({28'h0, cnt}, 32'h0);
    pins(1'b1, 1'b1, 1'b0, 1'b0, 4'hd);
    chk({28'h0, cnt}, 32'hd);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 4'h2);
    chk({28'h0, cnt}, 32'hd);
    $display("done: clear_load");
  endtask

  task automatic t_up;
    i_udc_pin_driver.pulse(1'b1, 4);
    i_udc_pin_driver.pulse(1'b1, 12);
    chk({28'h0, cnt}, 32'hf);
    chk({31'h0, carry_n}, 32'h1);
    pins(1'b0, 1'b1, 1'b0, 1'b1, 4'h2);
    chk({31'h0, carry_n}, 32'h0);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 4'h2);
    chk({27'h0, carry_n, cnt}, 32'h10);
    $display("done: up");
  endtask

  task automatic t_down;
    pins(1'b1, 1'b0, 1'b0, 1'b1, 4'h2);
    chk({27'h0, borrow_n, cnt}, 32'h0);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 4'h2);
    chk({27'h0, borrow_n, cnt}, 32'h1f);
    $display("done: down");
  endtask

  task automatic t_low_thru_load;
    pins(1'b1, 1'b0, 1'b0, 1'b0, 4'h5);
    chk({28'h0, cnt}, 32'h5);
    pins(1'b1, 1'b0, 1'b0, 1'b1, 4'h5);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    chk({28'h0, cnt}, 32'h4);
    pins(1'b0, 1'b0, 1'b0, 1'b1, 4'h5);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    chk({28'h0, cnt}, 32'h4);
    $display("done: low_thru_load");
  endtask

  task automatic t_regs;
    // One wrap each way so far; three up steps, two down, double rise not tallied
    bus(1'b0, udc_pkg::ADDR_EVENTS, 32'h0);
    chk(rd, 32'h3);
    bus(1'b1, udc_pkg::ADDR_EVENTS, 32'h1);
    bus(1'b0, udc_pkg::ADDR_EVENTS, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, udc_pkg::ADDR_TALLY, 32'h0);
    chk(rd, 32'h0002_0003);
    bus(1'b1, udc_pkg::ADDR_TALLY, 32'h0);
    bus(1'b0, udc_pkg::ADDR_TALLY, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, udc_pkg::ADDR_CTRL, 32'h1);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    chk({28'h0, cnt}, 32'h0);
    bus(1'b1, udc_pkg::ADDR_LOAD_VALUE, 32'h9);
    bus(1'b0, udc_pkg::ADDR_LOAD_VALUE, 32'h0);
    chk(rd, 32'h9);
    bus(1'b1, udc_pkg::ADDR_CTRL, 32'h2);
    pins(1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    bus(1'b0, udc_pkg::ADDR_STATUS, 32'h0);
    chk(rd & 32'hfff, 32'hb39);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    // Mid-run reset with the count away from zero
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(1'b0, udc_pkg::ADDR_LOAD_VALUE, 32'h0);
    chk({28'h0, cnt}, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, udc_pkg::ADDR_EVENTS, 32'h0);
    chk(rd, 32'h0);
    $display("done: regs");
  endtask

  task automatic wrap_up;
    $display("Counts: checked=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_clear_load();
    t_up();
    t_down();
    t_low_thru_load();
    t_regs();
    wrap_up();
  end

  // Whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end
endmodule

`default_nettype wire

// ==== bench/udc_pin_driver.sv ====
`default_nettype none

module udc_pin_driver (
  input  wire logic       i_ref_clk,
  output logic            o_up_count_clock,
  output logic            o_down_count_clock,
  output logic            o_master_clear,
  output logic            o_preset_load_n,
  output logic [3:0]      o_preset
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_up_count_clock = 1'b1;
    o_down_count_clock = 1'b1;
    o_master_clear = 1'b0;
    o_preset_load_n = 1'b1;
    o_preset = 4'h0;
  end

  // Each level held n+1 cycles; n below 4 returns before the count shows it
  task automatic drive(input logic u, d, c, l, input logic [3:0] p, input int n);
    @(posedge i_ref_clk);
    o_up_count_clock <= u;
    o_down_count_clock <= d;
    o_master_clear <= c;
    o_preset_load_n <= l;
    o_preset <= p;
    repeat (n) @(posedge i_ref_clk);
  endtask

  task automatic pulse(input logic up, input int n);
    drive(!up, up, 1'b0, 1'b1, o_preset, n);
    drive(1'b1, 1'b1, 1'b0, 1'b1, o_preset, n);
  endtask
endmodule

`default_nettype wire

// ==== core/udc_counter.sv ====
// Added by the designer: the register offsets and the AHB-Lite register port.
`default_nettype none

module udc_counter (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  // Counter pins
  input  wire logic        i_up_count_clock,
  input  wire logic        i_down_count_clock,
  input  wire logic        i_master_clear,
  input  wire logic        i_preset_load_n,
  input  wire logic        i_preset_bit0,
  input  wire logic        i_preset_bit1,
  input  wire logic        i_preset_bit2,
  input  wire logic        i_preset_bit3,
  output logic             o_count_bit0,
  output logic             o_count_bit1,
  output logic             o_count_bit2,
  output logic             o_count_bit3,
  output logic             o_carry_out_n,
  output logic             o_borrow_out_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [3:0]  count;
    logic        carry_n;
    logic        borrow_n;
    logic [3:0]  load_value;
    logic [1:0]  events;
    logic [15:0] up_tally;
    logic [15:0] down_tally;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } udc_state_t;

  udc_state_t st_reg;
  udc_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  udc_pin_if #(.WIDTH(udc_pkg::PIN_W)) pins ();

  logic [udc_pkg::PIN_W-1:0] pin_vec;

  assign pin_vec = {i_preset_bit3, i_preset_bit2, i_preset_bit1, i_preset_bit0,
                    i_preset_load_n, i_master_clear, i_down_count_clock,
                    i_up_count_clock};

  udc_pin_sync #(
    .WIDTH (udc_pkg::PIN_W),
    .RESET (udc_pkg::PIN_RESET)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_pins    (pin_vec),
    .pin_out   (pins.producer)
  );

  logic       up_level;
  logic       down_level;
  logic       up_rise;
  logic       down_rise;
  logic       clear_active;
  logic       load_active;
  logic [3:0] preset_value;

  assign up_level = pins.level[udc_pkg::PIN_UP];
  assign down_level = pins.level[udc_pkg::PIN_DOWN];
  assign up_rise = pins.rise[udc_pkg::PIN_UP];
  assign down_rise = pins.rise[udc_pkg::PIN_DOWN];
  assign clear_active = pins.level[udc_pkg::PIN_CLEAR];
  assign load_active = ~pins.level[udc_pkg::PIN_LOAD_N];
  assign preset_value = pins.level[udc_pkg::PIN_PRESET_LSB +: udc_pkg::COUNT_W];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic        addr_valid;
  logic [7:0]  addr_low;
  logic        wr_ctrl;
  logic        wr_load_value;
  logic        wr_events;
  logic        wr_tally;
  logic        soft_clear;
  logic        soft_load;
  logic [31:0] read_word;

  assign addr_valid = i_hsel & i_hready & (i_htrans == udc_pkg::HTRANS_NONSEQ);
  assign addr_low = i_haddr[udc_pkg::ADDR_W-1:0];
  assign wr_ctrl = st_reg.wr_pend & (st_reg.wr_addr == udc_pkg::ADDR_CTRL);
  assign wr_load_value = st_reg.wr_pend & (st_reg.wr_addr == udc_pkg::ADDR_LOAD_VALUE);
  assign wr_events = st_reg.wr_pend & (st_reg.wr_addr == udc_pkg::ADDR_EVENTS);
  assign wr_tally = st_reg.wr_pend & (st_reg.wr_addr == udc_pkg::ADDR_TALLY);
  assign soft_clear = wr_ctrl & i_hwdata[udc_pkg::CTRL_SOFT_CLEAR];
  assign soft_load = wr_ctrl & i_hwdata[udc_pkg::CTRL_SOFT_LOAD];

  // Unmapped offsets and the strobe-only control word read as zero
  always_comb begin
    read_word = 32'h0000_0000;
    case (addr_low)
      udc_pkg::ADDR_LOAD_VALUE: begin
        read_word[udc_pkg::COUNT_W-1:0] = st_reg.load_value;
      end
      udc_pkg::ADDR_STATUS: begin
        read_word[udc_pkg::COUNT_W-1:0] = st_reg.count;
        read_word[udc_pkg::STATUS_CARRY_N] = st_reg.carry_n;
        read_word[udc_pkg::STATUS_BORROW_N] = st_reg.borrow_n;
        read_word[udc_pkg::STATUS_PIN_LSB +: 4] = pins.level[3:0];
      end
      udc_pkg::ADDR_EVENTS: begin
        read_word[1:0] = st_reg.events;
      end
      udc_pkg::ADDR_TALLY: begin
        read_word[udc_pkg::TALLY_W-1:0] = st_reg.up_tally;
        read_word[udc_pkg::TALLY_DOWN_LSB +: udc_pkg::TALLY_W] = st_reg.down_tally;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic       step_up;
  logic       step_down;
  logic [1:0] event_set;
  logic [1:0] event_clr;

  always_comb begin
    st_next = st_reg;
    step_up = 1'b0;
    step_down = 1'b0;
    event_set = 2'h0;
    event_clr = 2'h0;

    // Bus: address phase captured, write data applied in data phase
    st_next.wr_pend = addr_valid & i_hwrite;
    st_next.wr_addr = addr_low;
    if (addr_valid && !i_hwrite) begin
      st_next.rdata = read_word;
    end
    if (wr_load_value) begin
      st_next.load_value = i_hwdata[udc_pkg::COUNT_W-1:0];
    end

    if (clear_active) begin
      st_next.count = udc_pkg::COUNT_ZERO;
    end else if (load_active) begin
      st_next.count = preset_value;
    end else if (soft_clear) begin
      st_next.count = udc_pkg::COUNT_ZERO;
    end else if (soft_load) begin
      st_next.count = st_reg.load_value;
    end else if (up_rise && down_rise) begin
      st_next.count = st_reg.count;
    end else if (up_rise) begin
      step_up = 1'b1;
      st_next.count = st_reg.count + 4'h1;
    end else if (down_rise) begin
      step_down = 1'b1;
      st_next.count = st_reg.count - 4'h1;
    end
    // No other path moves the count
    // Edge history runs through clear and load, so a clock held
    // low there still shows its next rise once they release

    // Carry copies the up clock at terminal count
    st_next.carry_n = ~((st_next.count == udc_pkg::COUNT_MAX) & ~up_level);
    // Borrow copies the down clock at zero
    st_next.borrow_n = ~((st_next.count == udc_pkg::COUNT_ZERO) & ~down_level);

    // Wrap events, set wins over a write-one clear
    event_set[udc_pkg::EVENT_WRAP_UP] = step_up & (st_reg.count == udc_pkg::COUNT_MAX);
    event_set[udc_pkg::EVENT_WRAP_DOWN] = step_down & (st_reg.count == udc_pkg::COUNT_ZERO);
    if (wr_events) begin
      event_clr = i_hwdata[1:0];
    end
    st_next.events = (st_reg.events & ~event_clr) | event_set;

    // Tallies saturate rather than wrap so software sees a ceiling
    if (wr_tally) begin
      st_next.up_tally = 16'h0000;
      st_next.down_tally = 16'h0000;
    end else begin
      if (step_up && (st_reg.up_tally != 16'hffff)) begin
        st_next.up_tally = st_reg.up_tally + 16'h0001;
      end
      if (step_down && (st_reg.down_tally != 16'hffff)) begin
        st_next.down_tally = st_reg.down_tally + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg.count <= 4'h0;
      st_reg.carry_n <= 1'b1;
      st_reg.borrow_n <= 1'b1;
      st_reg.load_value <= udc_pkg::LOAD_VALUE_RESET;
      st_reg.events <= 2'h0;
      st_reg.up_tally <= 16'h0000;
      st_reg.down_tally <= 16'h0000;
      st_reg.wr_pend <= 1'b0;
      st_reg.wr_addr <= 8'h00;
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Terminal outputs are clock copies for cascading
  assign o_carry_out_n = st_reg.carry_n;
  assign o_borrow_out_n = st_reg.borrow_n;
  assign o_count_bit0 = st_reg.count[0];
  assign o_count_bit1 = st_reg.count[1];
  assign o_count_bit2 = st_reg.count[2];
  assign o_count_bit3 = st_reg.count[3];
  assign o_hrdata = st_reg.rdata;
  // Zero wait states, every access completes OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp = udc_pkg::HRESP_OKAY;

endmodule

`default_nettype wire

// ==== core/udc_pin_if.sv ====
`default_nettype none

interface udc_pin_if #(
  parameter int unsigned WIDTH = 8
);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] rise;

  modport producer (output level, output rise);
  modport consumer (input level, input rise);
endinterface

`default_nettype wire

// ==== core/udc_pin_sync.sv ====
`default_nettype none

module udc_pin_sync #(
  parameter int unsigned      WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic [WIDTH-1:0] i_pins,
  udc_pin_if.producer           pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prior;
  } udc_sync_t;

  udc_sync_t st_reg;
  udc_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.meta = i_pins;
    st_next.stable = st_reg.meta;
    st_next.prior = st_reg.stable;
  end

  // Reset to idle levels so a released reset shows no false edge
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= {RESET, RESET, RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < WIDTH; g++) begin : g_edge
    assign pin_out.level[g] = st_reg.stable[g];
    assign pin_out.rise[g] = st_reg.stable[g] & ~st_reg.prior[g];
  end

endmodule

`default_nettype wire

// ==== core/udc_pkg.sv ====
// What this block does
// - Four-bit count changes only on up or down clock rising edges, clear, load, CTRL soft clear or soft load, and reset.
// - Up clock rising edge adds one while down clock stays high.
// - Down clock rising edge subtracts one while up clock stays high.
// - Master clear high forces the count to zero over both clocks.
// - Master clear wins over parallel load; preset ignored meanwhile.
// - Load low with clear inactive copies preset bits into the count.
// - Load is active low, clear active high, both independent of count clocks.
// - Carry idles high; low while count is fifteen and up clock low.
// - Borrow idles high; low exactly while count is zero and down clock low.
// - Carry and borrow copy clock waveforms to drive a next stage.
// - Clock low through clear or load: its next rising edge still counts.
// - Count wraps modulo sixteen in both directions.
`default_nettype none

package udc_pkg;

  localparam int unsigned COUNT_W = 4;
  localparam logic [3:0]  COUNT_MAX = 4'hf;
  localparam logic [3:0]  COUNT_ZERO = 4'h0;
  localparam int unsigned TALLY_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Pin vector layout into the synchroniser
  localparam int unsigned PIN_W = 8;
  localparam int unsigned PIN_UP = 0;
  localparam int unsigned PIN_DOWN = 1;
  localparam int unsigned PIN_CLEAR = 2;
  localparam int unsigned PIN_LOAD_N = 3;
  localparam int unsigned PIN_PRESET_LSB = 4;
  // Idle levels: clocks and load high, clear and data low
  localparam logic [7:0]  PIN_RESET = 8'h0b;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0]  ADDR_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_LOAD_VALUE = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_EVENTS = 8'h0c;
  localparam logic [7:0]  ADDR_TALLY = 8'h10;

  localparam int unsigned CTRL_SOFT_CLEAR = 0;
  localparam int unsigned CTRL_SOFT_LOAD = 1;
  localparam int unsigned STATUS_CARRY_N = 4;
  localparam int unsigned STATUS_BORROW_N = 5;
  localparam int unsigned STATUS_PIN_LSB = 8;
  localparam int unsigned EVENT_WRAP_UP = 0;
  localparam int unsigned EVENT_WRAP_DOWN = 1;
  localparam int unsigned TALLY_DOWN_LSB = 16;

  localparam logic [3:0]  LOAD_VALUE_RESET = 4'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY = 1'h0;

endpackage

`default_nettype wire
